// ---- hw/xform_params.svh ----
// register offsets, field positions, reset values and default filter settings
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
`ifndef XFORM_PARAMS_SVH
`define XFORM_PARAMS_SVH

`define REG_CTRL 6'h00
`define REG_MODE 6'h04
`define REG_HP_ALPHA 6'h08
`define REG_LP_ALPHA 6'h0C
`define REG_BQ_GAIN 6'h10
`define REG_BQ_A1 6'h14
`define REG_BQ_A2 6'h18
`define REG_BQ_TYPE 6'h1C
`define REG_STATUS 6'h20

`define CTRL_CHAN_EN 0
`define CTRL_XFORM_EN 1
`define CTRL_TO_TX 2
`define CTRL_TO_REC 3
`define CTRL_SRC_USER 4
`define CTRL_SAVE 8
`define CTRL_RESTART 9

`define CTRL_RESET 5'h0C
`define MODE_RESET 3'h0

`define NUM_PARAMS 6
`define PIDX_HP_ALPHA 0
`define PIDX_LP_ALPHA 1
`define PIDX_BQ_GAIN 2
`define PIDX_BQ_A1 3
`define PIDX_BQ_A2 4
`define PIDX_BQ_TYPE 5

// alphas are q0.15, biquad coefficients q2.14
`define DEF_HP_ALPHA 16'h0080
`define DEF_LP_ALPHA 16'h1000
`define DEF_BQ_GAIN 16'h0100
`define DEF_BQ_A1 16'h9000
`define DEF_BQ_A2 16'h1400
`define DEF_BQ_TYPE 16'h0000

`define ALPHA_SHIFT 15
`define BQ_SHIFT 14

`endif

// ---- hw/xform_pkg.sv ----
// types shared by the transform engine
// assumes xform_params.svh holds the numeric constants
package xform_pkg;

  typedef enum logic [2:0] {
    XF_PASS = 3'h0,
    XF_DIFF = 3'h1,
    XF_LPF = 3'h2,
    XF_HPF = 3'h3,
    XF_NOTCH = 3'h4,
    XF_BIQUAD = 3'h5
  } xform_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// ---- hw/sample_fifo.sv ----
// sample fifo with valid/ready on both sides
// assumes one clock; pointers carry one wrap bit so full and empty are exact
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] next_wr_ptr;
  logic [PW:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb begin
    level = wr_ptr - rd_ptr;
    in_ready = (level != (PW+1)'(DEPTH));
    out_valid = (level != '0);
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    out_data = mem[rd_ptr[PW-1:0]];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset: a word is only read after it was written
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end
endmodule

// ---- hw/one_pole_lpf.sv ----
// first-order low-pass stage: y += alpha * (x - y), alpha in q0.15
// assumes step is one pulse per sample; next_y is offered before the step lands
`timescale 1ns/10ps
`include "xform_params.svh"
module one_pole_lpf #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control
  input wire logic clear,
  input wire logic step,
  // data
  input wire logic signed [W-1:0] x,
  input wire logic [15:0] alpha,
  output logic signed [W-1:0] next_y
);
  logic signed [W-1:0] y;
  logic signed [W+17:0] prod;
  logic signed [W+1:0] sum;

  always_comb begin
    prod = (W+18)'($signed({{2{x[W-1]}}, x}) - $signed({{2{y[W-1]}}, y}))
         * $signed({1'b0, alpha});
    sum = $signed({{2{y[W-1]}}, y}) + (W+2)'(prod >>> `ALPHA_SHIFT);
    next_y = W'(sum);
  end

  // with alpha below one the state stays inside the input range
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      y <= '0;
    end else if (clear) begin
      y <= '0;
    end else if (step) begin
      y <= next_y;
    end
  end
endmodule

// ---- hw/channel_stream_transform_filter.sv ----
// per-channel transform engine with avalon-mm control registers
// assumes samples arrive as valid/ready words synchronous to clock
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "xform_params.svh"
module channel_stream_transform_filter
  import xform_pkg::*;
#(
  parameter int W = 24,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // sample input
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [W-1:0] in_data,
  // sample output
  output logic signed [W-1:0] out_data,
  output logic tx_valid,
  output logic rec_valid,
  input wire logic out_ready
);
  localparam int ACC = W + 20;

  function automatic logic signed [W-1:0] sat(input logic signed [ACC-1:0] v);
    logic signed [ACC-1:0] hi;
    logic signed [ACC-1:0] lo;
    hi = ACC'({1'b0, {(W-1){1'b1}}});
    lo = -hi - ACC'(1);
    if (v > hi) begin
      return W'(hi);
    end else if (v < lo) begin
      return W'(lo);
    end
    return W'(v);
  endfunction

  function automatic logic signed [ACC-1:0] ext(input logic signed [W-1:0] v);
    return ACC'(v);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic valid_code(input logic [2:0] c);
    return c <= XF_BIQUAD;
  endfunction

  // bus and control state
  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic [31:0] next_readdata;
  logic chan_en, xform_pend, xform_act, to_tx, to_rec, src_user;
  logic next_chan_en, next_xform_pend, next_xform_act, next_to_tx, next_to_rec;
  logic next_src_user;
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic [15:0] edit [0:`NUM_PARAMS-1];
  logic [15:0] user [0:`NUM_PARAMS-1];
  logic [15:0] next_edit [0:`NUM_PARAMS-1];
  logic [15:0] next_user [0:`NUM_PARAMS-1];
  logic [15:0] defs [0:`NUM_PARAMS-1];
  logic [15:0] act [0:`NUM_PARAMS-1];
  logic restart;
  logic [31:0] ctrl_word;
  logic [31:0] wmerged;

  // datapath state
  logic fifo_valid;
  logic fifo_ready;
  logic signed [W-1:0] x;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic signed [W-1:0] x1, x2, y1, y2;
  logic signed [W-1:0] next_x1, next_x2, next_y1, next_y2;
  logic signed [W-1:0] next_out_data;
  logic next_tx_valid, next_rec_valid;
  logic pop, step, out_busy;
  logic signed [W-1:0] hp_lpf_y, lp_in, lp_y, hp_y, bq_y, fx;
  logic signed [ACC-1:0] taps, bq_acc;
  xform_t eff_mode;

  assign defs[`PIDX_HP_ALPHA] = `DEF_HP_ALPHA;
  assign defs[`PIDX_LP_ALPHA] = `DEF_LP_ALPHA;
  assign defs[`PIDX_BQ_GAIN] = `DEF_BQ_GAIN;
  assign defs[`PIDX_BQ_A1] = `DEF_BQ_A1;
  assign defs[`PIDX_BQ_A2] = `DEF_BQ_A2;
  assign defs[`PIDX_BQ_TYPE] = `DEF_BQ_TYPE;

  // selector steers which set feeds the filters; on a save it also picks what is stored: the edit set if set, the defaults if clear
  always_comb begin
    for (int i = 0; i < `NUM_PARAMS; i++) begin
      act[i] = src_user ? user[i] : defs[i];
    end
  end

  // one wait cycle on every access, answer in the following cycle
  assign waitrequest = (read | write) & (bus_state == BUS_IDLE);

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`CTRL_CHAN_EN] = chan_en;
    ctrl_word[`CTRL_XFORM_EN] = xform_pend;
    ctrl_word[`CTRL_TO_TX] = to_tx;
    ctrl_word[`CTRL_TO_REC] = to_rec;
    ctrl_word[`CTRL_SRC_USER] = src_user;
    next_bus_state = bus_state;
    next_readdata = readdata;
    unique case (bus_state)
      BUS_IDLE: begin
        if (read | write) begin
          next_bus_state = BUS_ACK;
        end
        next_readdata = '0;
        if (read) begin
          unique case (address)
            `REG_CTRL: next_readdata = ctrl_word;
            `REG_MODE: next_readdata = {29'h0, mode};
            `REG_HP_ALPHA: next_readdata = {16'h0, edit[`PIDX_HP_ALPHA]};
            `REG_LP_ALPHA: next_readdata = {16'h0, edit[`PIDX_LP_ALPHA]};
            `REG_BQ_GAIN: next_readdata = {16'h0, edit[`PIDX_BQ_GAIN]};
            `REG_BQ_A1: next_readdata = {16'h0, edit[`PIDX_BQ_A1]};
            `REG_BQ_A2: next_readdata = {16'h0, edit[`PIDX_BQ_A2]};
            `REG_BQ_TYPE: next_readdata = {16'h0, edit[`PIDX_BQ_TYPE]};
            `REG_STATUS: next_readdata = {20'h0, 4'(fifo_level), 1'b0, eff_mode,
                                          2'b00, xform_act, chan_en};
            default: next_readdata = '0;
          endcase
        end
      end
      BUS_ACK: next_bus_state = BUS_IDLE;
    endcase
  end

  always_comb begin
    wmerged = '0;
    restart = 1'b0;
    next_chan_en = chan_en;
    next_xform_pend = xform_pend;
    next_xform_act = xform_act;
    next_to_tx = to_tx;
    next_to_rec = to_rec;
    next_src_user = src_user;
    next_mode = mode;
    for (int i = 0; i < `NUM_PARAMS; i++) begin
      next_edit[i] = edit[i];
      next_user[i] = user[i];
    end
    if (bus_state == BUS_ACK && write) begin
      unique case (address)
        `REG_CTRL: begin
          wmerged = merge(ctrl_word, writedata, byteenable);
          next_chan_en = wmerged[`CTRL_CHAN_EN];
          next_xform_pend = wmerged[`CTRL_XFORM_EN];
          next_to_tx = wmerged[`CTRL_TO_TX];
          next_to_rec = wmerged[`CTRL_TO_REC];
          next_src_user = wmerged[`CTRL_SRC_USER];
          restart = byteenable[1] & writedata[`CTRL_RESTART];
          if (byteenable[1] && writedata[`CTRL_SAVE]) begin
            for (int i = 0; i < `NUM_PARAMS; i++) begin
              next_user[i] = wmerged[`CTRL_SRC_USER] ? edit[i] : defs[i];
            end
          end
        end
        `REG_MODE: begin
          if (byteenable[0]) begin
            next_mode = writedata[2:0];
          end
        end
        `REG_HP_ALPHA, `REG_LP_ALPHA, `REG_BQ_GAIN, `REG_BQ_A1, `REG_BQ_A2,
        `REG_BQ_TYPE: begin
          wmerged = merge({16'h0, edit[3'(address[4:2] - 3'h2)]}, writedata, byteenable);
          next_edit[3'(address[4:2] - 3'h2)] = wmerged[15:0];
        end
        default: begin
        end
      endcase
    end
    if (restart) begin
      next_xform_act = next_xform_pend;
      if (next_xform_pend && !xform_act) begin
        next_mode = XF_PASS;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_state <= BUS_IDLE;
      readdata <= '0;
      {src_user, to_rec, to_tx, xform_pend, chan_en} <= `CTRL_RESET;
      xform_act <= 1'b0;
      mode <= `MODE_RESET;
      edit[`PIDX_HP_ALPHA] <= `DEF_HP_ALPHA;
      edit[`PIDX_LP_ALPHA] <= `DEF_LP_ALPHA;
      edit[`PIDX_BQ_GAIN] <= `DEF_BQ_GAIN;
      edit[`PIDX_BQ_A1] <= `DEF_BQ_A1;
      edit[`PIDX_BQ_A2] <= `DEF_BQ_A2;
      edit[`PIDX_BQ_TYPE] <= `DEF_BQ_TYPE;
      user[`PIDX_HP_ALPHA] <= `DEF_HP_ALPHA;
      user[`PIDX_LP_ALPHA] <= `DEF_LP_ALPHA;
      user[`PIDX_BQ_GAIN] <= `DEF_BQ_GAIN;
      user[`PIDX_BQ_A1] <= `DEF_BQ_A1;
      user[`PIDX_BQ_A2] <= `DEF_BQ_A2;
      user[`PIDX_BQ_TYPE] <= `DEF_BQ_TYPE;
    end else begin
      bus_state <= next_bus_state;
      readdata <= next_readdata;
      chan_en <= next_chan_en;
      xform_pend <= next_xform_pend;
      xform_act <= next_xform_act;
      to_tx <= next_to_tx;
      to_rec <= next_to_rec;
      src_user <= next_src_user;
      mode <= next_mode;
      for (int i = 0; i < `NUM_PARAMS; i++) begin
        edit[i] <= next_edit[i];
        user[i] <= next_user[i];
      end
    end
  end

  sample_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(x),
    .level(fifo_level)
  );

  // with the channel enabled a stalled output holds the fifo, which then back-pressures the source; disabled, the fifo keeps draining
  assign out_busy = (tx_valid | rec_valid) & ~out_ready;
  assign pop = fifo_valid & (~chan_en | ~out_busy);
  assign step = pop & chan_en & xform_act;
  assign eff_mode = valid_code(mode) ? xform_t'(mode) : XF_PASS;
  assign lp_in = (eff_mode == XF_NOTCH) ? hp_y : x;

  one_pole_lpf #(
    .W(W)
  ) u_hp_lpf (
    .clock(clock),
    .rstn(rstn),
    .clear(restart),
    .step(step),
    .x(x),
    .alpha(act[`PIDX_HP_ALPHA]),
    .next_y(hp_lpf_y)
  );

  one_pole_lpf #(
    .W(W)
  ) u_lp_lpf (
    .clock(clock),
    .rstn(rstn),
    .clear(restart),
    .step(step),
    .x(lp_in),
    .alpha(act[`PIDX_LP_ALPHA]),
    .next_y(lp_y)
  );

  always_comb begin
    hp_y = sat(ext(x) - ext(hp_lpf_y));
    // numerator k(1 +/- 2z^-1 + z^-2), denominator 1 + a1 z^-1 + a2 z^-2
    if (act[`PIDX_BQ_TYPE][0]) begin
      taps = ext(x) - (ext(x1) <<< 1) + ext(x2);
    end else begin
      taps = ext(x) + (ext(x1) <<< 1) + ext(x2);
    end
    bq_acc = ACC'(taps * $signed(act[`PIDX_BQ_GAIN]))
           - ACC'(ext(y1) * $signed(act[`PIDX_BQ_A1]))
           - ACC'(ext(y2) * $signed(act[`PIDX_BQ_A2]));
    bq_y = sat(bq_acc >>> `BQ_SHIFT);
    unique case (eff_mode)
      XF_PASS: fx = x;
      XF_DIFF: fx = sat(ext(x) - ext(x1));
      XF_LPF: fx = lp_y;
      XF_HPF: fx = hp_y;
      XF_NOTCH: fx = lp_y;
      XF_BIQUAD: fx = bq_y;
      default: fx = x;
    endcase
  end

  always_comb begin
    next_x1 = x1;
    next_x2 = x2;
    next_y1 = y1;
    next_y2 = y2;
    next_out_data = out_data;
    next_tx_valid = tx_valid & ~out_ready;
    next_rec_valid = rec_valid & ~out_ready;
    if (restart) begin
      next_x1 = '0;
      next_x2 = '0;
      next_y1 = '0;
      next_y2 = '0;
    end else if (step) begin
      next_x1 = x;
      next_x2 = x1;
      next_y1 = bq_y;
      next_y2 = y1;
    end
    if (pop && chan_en) begin
      next_out_data = xform_act ? fx : x;
      next_tx_valid = to_tx;
      next_rec_valid = to_rec;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
      out_data <= '0;
      tx_valid <= 1'b0;
      rec_valid <= 1'b0;
    end else begin
      x1 <= next_x1;
      x2 <= next_x2;
      y1 <= next_y1;
      y2 <= next_y2;
      out_data <= next_out_data;
      tx_valid <= next_tx_valid;
      rec_valid <= next_rec_valid;
    end
  end
endmodule

// ---- test/stream_filter_assertions.sv ----
// checker for the transform engine: bus handshake and output stream
// assumes it is bound to the engine top and sees only its ports
`timescale 1ns/10ps
module stream_filter_assertions #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // stream
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic signed [W-1:0] in_data,
  input wire logic signed [W-1:0] out_data,
  input wire logic tx_valid,
  input wire logic rec_valid,
  input wire logic out_ready
);
  logic [15:0] taken;
  logic [15:0] given;
  logic [15:0] next_taken;
  logic [15:0] next_given;
  always_comb begin
    next_taken = taken + 16'(in_valid && in_ready);
    next_given = given + 16'((tx_valid || rec_valid) && out_ready);
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      taken <= 16'h0000;
      given <= 16'h0000;
    end else begin
      taken <= next_taken;
      given <= next_given;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait");
  idle_nowait_a: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised without access");
  single_ack_a: assert property ((read || write) && !waitrequest |=> waitrequest || !(read || write))
    else $error("two acks in a row");
  unmapped_zero_a: assert property (read && !waitrequest && address > 6'h20 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (read && !waitrequest ##1 !(read || write) |-> $stable(readdata))
    else $error("read data moved while idle");
  tx_hold_a: assert property (tx_valid && !out_ready |=> tx_valid && $stable(out_data))
    else $error("transmit sample dropped under stall");
  rec_hold_a: assert property (rec_valid && !out_ready |=> rec_valid && $stable(out_data))
    else $error("record sample dropped under stall");
  no_extra_a: assert property (given <= taken)
    else $error("more outputs than inputs");
  quiet_start_a: assert property ($rose(rstn) |-> !tx_valid && !rec_valid)
    else $error("output valid right after reset");
endmodule

bind channel_stream_transform_filter stream_filter_assertions #(.W(W)) u_stream_filter_assertions (.*);

// ---- test/sample_sink.sv ----
// far-side model: downstream sink for the engine output
// assumes one clock; stall holds out_ready low to back up the stream
`timescale 1ns/10ps
module sample_sink (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // stream from the engine
  input wire logic signed [23:0] out_data,
  input wire logic tx_valid,
  input wire logic rec_valid,
  output logic out_ready,
  // bench side
  input wire logic stall,
  output logic [15:0] got,
  output logic signed [23:0] last,
  output logic [1:0] route
);
  assign out_ready = !stall;
  // one ready beat takes both paths at once
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      got <= 16'h0000;
      last <= 24'h000000;
      route <= 2'b00;
    end else if ((tx_valid || rec_valid) && out_ready) begin
      got <= got + 16'h0001;
      last <= out_data;
      route <= {tx_valid, rec_valid};
    end
  end
endmodule

// ---- test/test_channel_stream_transform_filter.sv ----
// self-checking bench for the transform engine
// assumes the sink model consumes the output stream
`timescale 1ns/10ps
`include "xform_params.svh"
module test_channel_stream_transform_filter;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic in_valid = 1'b0;
  logic in_ready;
  logic signed [23:0] in_data = 24'h000000;
  logic signed [23:0] out_data;
  logic tx_valid;
  logic rec_valid;
  logic out_ready;
  logic stall = 1'b0;
  logic [15:0] got;
  logic signed [23:0] last;
  logic [1:0] route;
  logic [15:0] c;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #12.5 clock = ~clock;
  channel_stream_transform_filter u_channel_stream_transform_filter (
    .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_data(out_data), .tx_valid(tx_valid),
    .rec_valid(rec_valid), .out_ready(out_ready));
  sample_sink u_sample_sink (.clock(clock), .rstn(rstn), .out_data(out_data),
    .tx_valid(tx_valid), .rec_valid(rec_valid), .out_ready(out_ready),
    .stall(stall), .got(got), .last(last), .route(route));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("readdata", e, q);
  endtask
  task automatic push(input logic signed [23:0] x);
    @(posedge clock);
    in_data <= x;
    in_valid <= 1'b1;
    do @(posedge clock); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask
  task automatic send(input logic signed [23:0] x, input logic signed [23:0] e);
    logic [15:0] c0;
    c0 = got;
    push(x);
    while (got === c0) @(posedge clock);
    chk("out_data", e, last);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd(`REG_CTRL, 32'h0000000C);
    rd(`REG_MODE, 32'h00000000);
    rd(6'h3C, 32'h00000000);
    wr(`REG_MODE, 32'h00000001);
    c = got;
    push(24'h000123);
    repeat (12) @(posedge clock);
    chk("dropped", 32'(c), 32'(got));
    $display("registers and disabled channel done");
    // pending enable with no restart: still raw, not differenced
    wr(`REG_CTRL, 32'h0000000F);
    send(24'h0001F4, 24'h0001F4);
    send(24'h0002BC, 24'h0002BC);
    wr(`REG_CTRL, 32'h0000020F);
    rd(`REG_MODE, 32'h00000000);
    send(24'hFFFFF9, 24'hFFFFF9);
    wr(`REG_MODE, 32'h00000001);
    wr(`REG_CTRL, 32'h0000020F);
    send(24'h000064, 24'h000064);
    send(24'h00012C, 24'h0000C8);
    send(24'h0000FA, 24'hFFFFCE);
    wr(`REG_MODE, 32'h00000007);
    rd(`REG_STATUS, 32'h00000003);
    send(24'h00002A, 24'h00002A);
    wr(`REG_MODE, 32'h00000002);
    wr(`REG_CTRL, 32'h0000020F);
    send(24'h001F40, 24'h0003E8);
    send(24'h001F40, 24'h000753);
    wr(`REG_MODE, 32'h00000003);
    wr(`REG_CTRL, 32'h0000020F);
    send(24'h001F40, 24'h001F21);
    wr(`REG_MODE, 32'h00000004);
    wr(`REG_CTRL, 32'h0000020F);
    send(24'h001F40, 24'h0003E4);
    wr(`REG_MODE, 32'h00000005);
    wr(`REG_CTRL, 32'h0000020F);
    rd(`REG_STATUS, 32'h00000053);
    send(24'h001F40, 24'h00007D);
    send(24'h001F40, 24'h000251);
    $display("transforms done");
    wr(`REG_BQ_TYPE, 32'h00000001);
    wr(`REG_CTRL, 32'h0000031F);
    send(24'h001F40, 24'h00007D);
    send(24'h001F40, 24'h00005D);
    wr(`REG_CTRL, 32'h0000000F);
    wr(`REG_CTRL, 32'h0000021F);
    send(24'h001F40, 24'h00007D);
    send(24'h001F40, 24'h00005D);
    wr(`REG_CTRL, 32'h0000010F);
    rd(`REG_BQ_TYPE, 32'h00000001);
    wr(`REG_CTRL, 32'h0000021F);
    send(24'h001F40, 24'h00007D);
    send(24'h001F40, 24'h000251);
    $display("parameter sets done");
    wr(`REG_MODE, 32'h00000000);
    wr(`REG_CTRL, 32'h00000007);
    send(24'h000005, 24'h000005);
    chk("route", 32'h2, 32'(route));
    wr(`REG_CTRL, 32'h0000000B);
    send(24'h000006, 24'h000006);
    chk("route", 32'h1, 32'(route));
    $display("routing done");
    wr(`REG_CTRL, 32'h0000000F);
    stall <= 1'b1;
    c = got;
    n = 0;
    @(posedge clock);
    in_data <= 24'h000000;
    in_valid <= 1'b1;
    repeat (20) begin
      @(posedge clock);
      if (in_ready === 1'b1) begin
        n++;
        in_data <= 24'(n);
      end
    end
    chk("in_ready", 32'h0, 32'(in_ready));
    in_valid <= 1'b0;
    stall <= 1'b0;
    while (got !== c + 16'(n)) @(posedge clock);
    chk("drained", 32'(c + 16'(n)), 32'(got));
    chk("last", 32'(n - 1), 32'(last));
    $display("buffer done");
    // a second reset must drop the active transform back to off
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(`REG_CTRL, 32'h0000000C);
    rd(`REG_STATUS, 32'h00000000);
    $display("reset done");
    summarize();
  end
endmodule
